// file: inc/tpc_defines.vh
`ifndef TPC_DEFINES_VH
`define TPC_DEFINES_VH
// register byte addresses
`define TPC_ADDR_CLKOUT_CONTROL 8'h00
`define TPC_ADDR_TIMER_CONFIG   8'h04
`define TPC_ADDR_TIMED_ACCESS   8'h08
`define TPC_ADDR_STATUS         8'h0c
// clkout_control fields
`define TPC_COR_ENABLE_BIT      0
`define TPC_COR_DIV_LO          1
`define TPC_COR_DIV_HI          2
`define TPC_COR_CAN0_LO         3
`define TPC_COR_CAN0_HI         4
`define TPC_COR_CAN1_LO         5
`define TPC_COR_CAN1_HI         6
`define TPC_COR_IRDA_BIT        7
`define TPC_COR_RESET           8'h00
// timer_config fields
`define TPC_CFG_T1_DIV13_BIT    0
`define TPC_CFG_T2_DIV13_BIT    1
`define TPC_CFG_RESET           2'h0
// timed-access key bytes
`define TPC_TA_KEY1             8'haa
`define TPC_TA_KEY2             8'h55
// timed-access window in clocks after the second key
`define TPC_TA_WINDOW           3'h4
// divide-by-13 count
`define TPC_DIV13               4'hd
`define TPC_DIV13_LAST          4'hc
// divide by 16 for baud-to-encoder clock
`define TPC_X16_SHIFT           4
`endif

// file: design/tpc_timer_prescale_clkout.v
`timescale 1ns/1ns
// How it works
// [RL1] div13 select swaps timer pin count input for an oscillator/13 tick
// [RL2] timer 1 and timer 2 each own a separate div13 select bit
// [RL3] timer 1 div13 select applies in every timer 1 mode
// [RL4] timer 2 as baud generator ignores its div13 select bit
// [RL5] baud mode when reload select is 0 and rx or tx clock set
// [RL6] clock output is free-running 50 percent square wave when enabled
// [RL7] divide field bits 2..1 pick system clock over 2, 4, 6 or 8
// [RL8] enable bit 0 must be set; writes go through timed access
// [RL9] software sets pin latch, else pin shows latch, not the clock
// [RL10] infrared select plus enable gives sixteen times serial 0 baud
// [RL11] software sets up serial 0 before infrared clock and enable
// [RL12] timer 2 rx clock forces serial 1 rx baud-double bit to 0
// [RL13] timer 2 tx clock forces serial 1 tx baud-double bit to 0
// [RL14] every clock output control field writes only via timed access
// [RL15] both timer 2 clocks set: program serial 1 for half rate
// [RL16] enable clear stops generator, pin returns to port latch
`include "tpc_defines.vh"

// register map, one word each, only the low bits are kept:
//   0x00 clock output control, guarded by the timed-access window
//   0x04 timer config, div13 select for timer 1 (bit 0) and 2 (bit 1)
//   0x08 timed-access key register, write only, reads as zero
//   0x0c status: driving, pin value, baud mode, window, down count
// the bus slave never stalls: hreadyout stays high and the response
// is always okay, so a master can issue transfers back to back.
// hsize is not decoded; every access is treated as a whole word, so
// a narrow write still lands its low byte in the register.
// everything runs on the one system clock; the oscillator/13 tick and
// the clock output are count-based enables, never derived clocks, so
// no second clock domain exists anywhere in this block.
// all outputs are registered, so each follows its inputs by at least one clock.

module tpc_timer_prescale_clkout (
	// clock and reset
	input  wire        CLK_I,
	input  wire        RST_I,
	// ahb-lite slave
	input  wire        HSEL_I,
	input  wire [7:0]  HADDR_I,
	input  wire [1:0]  HTRANS_I,
	input  wire        HWRITE_I,
	input  wire [2:0]  HSIZE_I,
	input  wire [31:0] HWDATA_I,
	input  wire        HREADY_I,
	output reg  [31:0] HRDATA_O,
	output reg         HREADYOUT_O,
	output reg         HRESP_O,
	// timer inputs and controls
	input  wire        T1_PIN_I,
	input  wire        T2_PIN_I,
	input  wire        TIMER2_RELOAD_SELECT_N_I,
	input  wire        TIMER2_RX_CLOCK_SELECT_I,
	input  wire        TIMER2_TX_CLOCK_SELECT_I,
	input  wire        TIMER2_DOWN_COUNT_ENABLE_I,
	// serial port clocks
	input  wire        SERIAL0_BAUD_TICK_I,
	input  wire        SERIAL1_BAUD_DOUBLE_I,
	// pin latch
	input  wire        PORT_LATCH_I,
	// timer count sources
	output reg         T1_COUNT_O,
	output reg         T2_COUNT_O,
	output reg         TIMER2_BAUD_MODE_O,
	// serial 1 effective baud-double
	output reg         SERIAL1_RX_DOUBLE_O,
	output reg         SERIAL1_TX_DOUBLE_O,
	// clock output pin, oe low drives
	output reg         CLOCK_OUTPUT_PIN_O,
	output reg         CLOCK_OUTPUT_PIN_OE_N_O,
	// can prescale bits
	output reg  [1:0]  CAN0_PRESCALE_HIGH_O,
	output reg  [1:0]  CAN1_PRESCALE_HIGH_O
);
	localparam [1:0] HTRANS_NONSEQ = 2'h2;
	localparam [1:0] HTRANS_SEQ    = 2'h3;
	// timed-access states, one-hot
	localparam [2:0] TA_IDLE = 3'h1;
	localparam [2:0] TA_KEY1 = 3'h2;
	localparam [2:0] TA_OPEN = 3'h4;

	reg  [7:0] clkout_control;
	reg  [1:0] timer_config;
	reg  [2:0] ta_state;
	reg  [2:0] ta_count;
	// captured address phase
	reg        dp_write;
	reg        dp_valid;
	reg  [7:0] dp_addr;

	wire addr_ok = HSEL_I && HREADY_I &&
		(HTRANS_I == HTRANS_NONSEQ || HTRANS_I == HTRANS_SEQ);
	wire wr_cor = dp_valid && dp_write &&
		dp_addr == `TPC_ADDR_CLKOUT_CONTROL;
	wire wr_cfg = dp_valid && dp_write &&
		dp_addr == `TPC_ADDR_TIMER_CONFIG;
	wire wr_ta = dp_valid && dp_write &&
		dp_addr == `TPC_ADDR_TIMED_ACCESS;
	wire ta_open = (ta_state == TA_OPEN);

	wire clkout_enable = clkout_control[`TPC_COR_ENABLE_BIT];
	wire infrared_clock_select = clkout_control[`TPC_COR_IRDA_BIT];
	wire [1:0] clkout_divide_select =
		clkout_control[`TPC_COR_DIV_HI:`TPC_COR_DIV_LO];
	wire baud_mode = !TIMER2_RELOAD_SELECT_N_I &&
		(TIMER2_RX_CLOCK_SELECT_I || TIMER2_TX_CLOCK_SELECT_I); // RL5

	// address phase capture; slave is zero-wait so hreadyout stays high
	always @(posedge CLK_I) begin
		if (RST_I) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr <= 8'h00;
			HREADYOUT_O <= 1'b1;
			HRESP_O <= 1'b0;
		end else begin
			HREADYOUT_O <= 1'b1;
			HRESP_O <= 1'b0;
			if (HREADY_I) begin
				dp_valid <= addr_ok;
				dp_write <= HWRITE_I;
				dp_addr <= HADDR_I;
			end
		end
	end

	// read data registered at the address phase so it stands in data phase
	always @(posedge CLK_I) begin
		if (RST_I) begin
			HRDATA_O <= 32'h0000_0000;
		end else if (addr_ok && !HWRITE_I) begin
			case (HADDR_I)
			`TPC_ADDR_CLKOUT_CONTROL: HRDATA_O <= {24'h000000,
				clkout_control};
			`TPC_ADDR_TIMER_CONFIG: HRDATA_O <= {30'h0,
				timer_config};
			`TPC_ADDR_STATUS: HRDATA_O <= {27'h0,
				TIMER2_DOWN_COUNT_ENABLE_I, ta_open,
				baud_mode, CLOCK_OUTPUT_PIN_O,
				!CLOCK_OUTPUT_PIN_OE_N_O};
			default: HRDATA_O <= 32'h0000_0000;
			endcase
		end
	end

	// timed access: key1 then key2 opens a short window for one write
	// any other transfer between the two keys drops back to idle, so a
	// stray access from an interrupt handler cannot leave the window
	// half armed; the window also times out on its own so a forgotten
	// sequence cannot unlock a much later write by accident
	always @(posedge CLK_I) begin
		if (RST_I) begin
			ta_state <= TA_IDLE;
			ta_count <= 3'h0;
		end else begin
			case (ta_state)
			TA_IDLE: begin
				if (wr_ta && HWDATA_I[7:0] == `TPC_TA_KEY1)
					ta_state <= TA_KEY1;
			end
			TA_KEY1: begin
				if (wr_ta && HWDATA_I[7:0] == `TPC_TA_KEY2) begin
					ta_state <= TA_OPEN;
					ta_count <= `TPC_TA_WINDOW;
				end else if (dp_valid) begin
					ta_state <= TA_IDLE;
				end
			end
			TA_OPEN: begin
				// window closes on the protected write or on timeout
				if (wr_cor || ta_count == 3'h1)
					ta_state <= TA_IDLE;
				ta_count <= ta_count - 3'h1;
			end
			default: ta_state <= TA_IDLE;
			endcase
		end
	end

	// protected control register and plain timer config
	always @(posedge CLK_I) begin
		if (RST_I) begin
			clkout_control <= `TPC_COR_RESET;
			timer_config <= `TPC_CFG_RESET;
		end else begin
			if (wr_cor && ta_open)                 // RL14
				clkout_control <= HWDATA_I[7:0];   // RL8
			if (wr_cfg)                            // RL2
				timer_config <= HWDATA_I[1:0];
		end
	end

	// oscillator/13 tick shared by both timers
	// one free-running counter serves both timers; sharing it keeps the
	// two timebases in phase, which costs nothing since each timer only
	// sees a one-cycle tick every thirteen clocks
	reg [3:0] div13_count;
	reg       div13_tick;
	always @(posedge CLK_I) begin
		if (RST_I) begin
			div13_count <= 4'h0;
			div13_tick <= 1'b0;
		end else begin
			div13_tick <= (div13_count == `TPC_DIV13_LAST);
			if (div13_count == `TPC_DIV13_LAST)
				div13_count <= 4'h0;
			else
				div13_count <= div13_count + 4'h1;
		end
	end

	// count source selection per timer
	// timer 1 obeys its select bit in every mode; timer 2 falls back to its
	// pin whenever it runs as a baud generator, whatever its select bit
	always @(posedge CLK_I) begin
		if (RST_I) begin
			T1_COUNT_O <= 1'b0;
			T2_COUNT_O <= 1'b0;
			TIMER2_BAUD_MODE_O <= 1'b0;
		end else begin
			TIMER2_BAUD_MODE_O <= baud_mode;
			T1_COUNT_O <= timer_config[`TPC_CFG_T1_DIV13_BIT] ?
				div13_tick : T1_PIN_I;        // RL1 RL3
			if (timer_config[`TPC_CFG_T2_DIV13_BIT] && !baud_mode)
				T2_COUNT_O <= div13_tick;     // RL1
			else
				T2_COUNT_O <= T2_PIN_I;       // RL4
		end
	end

	// serial 1 baud-double masking
	// a timer 2 clock select hides the software double bit from the
	// matching serial 1 direction only; the other direction keeps it
	always @(posedge CLK_I) begin
		if (RST_I) begin
			SERIAL1_RX_DOUBLE_O <= 1'b0;
			SERIAL1_TX_DOUBLE_O <= 1'b0;
		end else begin
			SERIAL1_RX_DOUBLE_O <= SERIAL1_BAUD_DOUBLE_I &&
				!TIMER2_RX_CLOCK_SELECT_I;    // RL12
			SERIAL1_TX_DOUBLE_O <= SERIAL1_BAUD_DOUBLE_I &&
				!TIMER2_TX_CLOCK_SELECT_I;    // RL13
		end
	end

	// square wave: toggle every half period; the half period is
	// 1..4 clocks, giving divide by 2, 4, 6, 8 with exact 50% duty
	// clearing the enable parks the generator at zero, so the next
	// enable always starts from a known phase
	// a change of divide field while running takes effect at once, in
	// the half period in flight, which may stretch by up to 3 clocks
	reg [1:0] half_count;
	reg       sq_wave;
	always @(posedge CLK_I) begin
		if (RST_I || !clkout_enable) begin
			half_count <= 2'h0;                // RL16
			sq_wave <= 1'b0;
		end else if (infrared_clock_select) begin
			// baud tick assumed at 16x-baud rate / 2 per toggle
			if (SERIAL0_BAUD_TICK_I) begin    // RL10
				sq_wave <= ~sq_wave;
			end
		end else if (half_count == clkout_divide_select) begin
			half_count <= 2'h0;                // RL7
			sq_wave <= ~sq_wave;               // RL6
		end else begin
			half_count <= half_count + 2'h1;
		end
	end

	// pin drive: clock only when enabled and latch set, else latch
	// the pin is always driven; a low latch shows a steady low, which
	// is how software stops the clock without touching the guarded bits
	// the can prescale bits are plain copies of the guarded register
	always @(posedge CLK_I) begin
		if (RST_I) begin
			CLOCK_OUTPUT_PIN_O <= 1'b1;
			CLOCK_OUTPUT_PIN_OE_N_O <= 1'b0;
			CAN0_PRESCALE_HIGH_O <= 2'h0;
			CAN1_PRESCALE_HIGH_O <= 2'h0;
		end else begin
			CLOCK_OUTPUT_PIN_OE_N_O <= 1'b0;
			CAN0_PRESCALE_HIGH_O <=
				clkout_control[`TPC_COR_CAN0_HI:`TPC_COR_CAN0_LO];
			CAN1_PRESCALE_HIGH_O <=
				clkout_control[`TPC_COR_CAN1_HI:`TPC_COR_CAN1_LO];
			if (clkout_enable && PORT_LATCH_I)   // RL8 RL9
				CLOCK_OUTPUT_PIN_O <= sq_wave;
			else
				CLOCK_OUTPUT_PIN_O <= PORT_LATCH_I;  // RL16
		end
	end
endmodule

// file: tb/tpc_props.sv
`timescale 1ns/1ns
module tpc_props (
	// clock, reset and bus answer
	input wire        CLK_I, RST_I, HREADYOUT_O, HRESP_O,
	// timer and serial controls
	input wire        T1_PIN_I, T2_PIN_I, TIMER2_RELOAD_SELECT_N_I,
	input wire        TIMER2_RX_CLOCK_SELECT_I, TIMER2_TX_CLOCK_SELECT_I,
	input wire        SERIAL1_BAUD_DOUBLE_I, PORT_LATCH_I,
	// design results
	input wire        T1_COUNT_O, T2_COUNT_O, TIMER2_BAUD_MODE_O,
	input wire        SERIAL1_RX_DOUBLE_O, SERIAL1_TX_DOUBLE_O,
	input wire        CLOCK_OUTPUT_PIN_O, CLOCK_OUTPUT_PIN_OE_N_O
);
	// one domain, so clock and reset are given once
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	// enable is clear after reset, so the pin shows the latch
	chk_reset_pin: assert property ($fell(RST_I) |-> CLOCK_OUTPUT_PIN_O)
		else $error("pin not high after reset");
	chk_bus_okay: assert property (HREADYOUT_O && !HRESP_O)
		else $error("bus answer not ready okay");
	chk_pin_drives: assert property (!CLOCK_OUTPUT_PIN_OE_N_O)
		else $error("pin not driven");
	chk_latch_low: assert property (!$past(PORT_LATCH_I) |-> !CLOCK_OUTPUT_PIN_O)
		else $error("clock shown with latch low");
	chk_baud_mode: assert property (TIMER2_BAUD_MODE_O == $past(
		!TIMER2_RELOAD_SELECT_N_I && (TIMER2_RX_CLOCK_SELECT_I ||
		TIMER2_TX_CLOCK_SELECT_I))) else $error("baud mode decode");
	chk_rx_double: assert property (!$past(RST_I) |->
		SERIAL1_RX_DOUBLE_O ==
		$past(SERIAL1_BAUD_DOUBLE_I && !TIMER2_RX_CLOCK_SELECT_I))
		else $error("rx double not masked");
	chk_tx_double: assert property (!$past(RST_I) |->
		SERIAL1_TX_DOUBLE_O ==
		$past(SERIAL1_BAUD_DOUBLE_I && !TIMER2_TX_CLOCK_SELECT_I))
		else $error("tx double not masked");
	// in baud mode the pin feeds timer 2 whatever its div13 bit says
	chk_t2_baud_pin: assert property (TIMER2_BAUD_MODE_O &&
		$past(TIMER2_BAUD_MODE_O) |-> T2_COUNT_O == $past(T2_PIN_I))
		else $error("t2 not on pin in baud mode");
	// a tick with the pin low is one cycle wide, then a long gap
	chk_t1_tick: assert property ($rose(T1_COUNT_O) &&
		!$past(T1_PIN_I) |=> !T1_COUNT_O [*8]) else $error("t1 tick");
endmodule
bind tpc_timer_prescale_clkout tpc_props tpc_props_i (.*);

// file: tb/tpc_ir_encoder.sv
`timescale 1ns/1ns
// encoder stand-in: it only consumes the modulation clock
module tpc_ir_encoder (
	// modulation clock from the clock output pin
	input  wire clk16_i,
	// rising edges seen so far
	output int  edges_o
);
	// the encoder acts on rising edges only, so count those
	always @(posedge clk16_i) edges_o <= edges_o + 1;
endmodule

// file: tb/tb.sv
`timescale 1ns/1ns
`include "tpc_defines.vh"
`define CK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
	$display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module tb;
	// inputs, each with a time zero value
	logic CLK_I = 0, RST_I = 1, HSEL_I = 1, HWRITE_I = 0;
	logic [7:0] HADDR_I = 8'h00;
	logic [1:0] HTRANS_I = 2'h0;
	logic [2:0] HSIZE_I = 3'h2, bk = 3'h0;
	logic [31:0] HWDATA_I = 32'h0, rdat;
	logic T1_PIN_I = 0, T2_PIN_I = 0, TIMER2_DOWN_COUNT_ENABLE_I = 0;
	logic TIMER2_RELOAD_SELECT_N_I = 1, TIMER2_RX_CLOCK_SELECT_I = 0;
	logic TIMER2_TX_CLOCK_SELECT_I = 0, SERIAL0_BAUD_TICK_I = 0;
	logic SERIAL1_BAUD_DOUBLE_I = 1, PORT_LATCH_I = 1;
	// outputs
	wire [31:0] HRDATA_O;
	wire [1:0] CAN0_PRESCALE_HIGH_O, CAN1_PRESCALE_HIGH_O;
	wire HREADYOUT_O, HRESP_O, T1_COUNT_O, T2_COUNT_O, TIMER2_BAUD_MODE_O;
	wire SERIAL1_RX_DOUBLE_O, SERIAL1_TX_DOUBLE_O, CLOCK_OUTPUT_PIN_O;
	wire CLOCK_OUTPUT_PIN_OE_N_O;
	wire HREADY_I = HREADYOUT_O; // the only slave
	int mismatches = 0, n_tests = 0, cyc = 0, n, e0, edges = 0;
	tpc_timer_prescale_clkout tpc_timer_prescale_clkout_i (.*);
	tpc_ir_encoder tpc_ir_encoder_i (.clk16_i(CLOCK_OUTPUT_PIN_O),
		.edges_o(edges));
	initial begin
		forever #50 CLK_I = ~CLK_I;
	end
	// serial 0 tick every fifth clock, and the hang limit
	always @(posedge CLK_I) begin
		bk <= (bk == 3'h4) ? 3'h0 : bk + 3'h1;
		SERIAL0_BAUD_TICK_I <= (bk == 3'h4);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			conclude;
		end
	end
	// one whole-word transfer; read data taken at the data phase edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		HADDR_I <= a;
		HWRITE_I <= w;
		HTRANS_I <= 2'h2;
		do @(posedge CLK_I); while (HREADY_I !== 1'b1);
		HTRANS_I <= 2'h0;
		HWDATA_I <= d;
		do @(posedge CLK_I); while (HREADY_I !== 1'b1);
		rdat = HRDATA_O;
	endtask
	// key pair, then the one protected write it allows
	task ta(input logic [7:0] v);
		xfer(1, `TPC_ADDR_TIMED_ACCESS, {24'h0, `TPC_TA_KEY1});
		xfer(1, `TPC_ADDR_TIMED_ACCESS, {24'h0, `TPC_TA_KEY2});
		xfer(1, `TPC_ADDR_CLKOUT_CONTROL, {24'h0, v});
	endtask
	// clocks until the pin changes; bounded so a dead pin cannot hang
	task half(output int k);
		logic p;
		p = CLOCK_OUTPUT_PIN_O;
		k = 0;
		do begin
			@(posedge CLK_I);
			k++;
		end while (CLOCK_OUTPUT_PIN_O === p && k < 40);
	endtask
	// count source pulses over ten tick periods
	task pulses(input logic t2, output int k);
		k = 0;
		repeat (130) begin
			@(posedge CLK_I);
			k += t2 ? T2_COUNT_O : T1_COUNT_O;
		end
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge CLK_I);
		RST_I <= 0;
		xfer(0, `TPC_ADDR_CLKOUT_CONTROL, 0);
		`CK(rdat[7:0], `TPC_COR_RESET)
		xfer(1, `TPC_ADDR_CLKOUT_CONTROL, 32'h3);
		xfer(0, `TPC_ADDR_CLKOUT_CONTROL, 0);
		`CK(rdat[7:0], 8'h00)
		xfer(0, 8'h40, 32'h0);
		`CK(rdat, 32'h0)
		xfer(0, `TPC_ADDR_STATUS, 0);
		`CK(rdat[4:0], 5'h03)
		$display("test registers done");
		// every divide choice: both halves of the period
		for (int i = 0; i < 4; i++) begin
			ta({3'h2, 2'h1, i[1:0], 1'b1});
			xfer(0, `TPC_ADDR_CLKOUT_CONTROL, 0);
			`CK(rdat[7:0], {3'h2, 2'h1, i[1:0], 1'b1})
			`CK({CAN1_PRESCALE_HIGH_O, CAN0_PRESCALE_HIGH_O}, 4'h9)
			half(n);
			half(n);
			`CK(n, i + 1)
			half(n);
			`CK(n, i + 1)
		end
		$display("test divide done");
		// disable, then a write with no keys must not re-enable
		ta(8'h00);
		xfer(1, `TPC_ADDR_CLKOUT_CONTROL, 32'h1);
		repeat (3) @(posedge CLK_I);
		`CK(CLOCK_OUTPUT_PIN_O, 1'b1)
		PORT_LATCH_I <= 0;
		repeat (3) @(posedge CLK_I);
		`CK(CLOCK_OUTPUT_PIN_O, 1'b0)
		PORT_LATCH_I <= 1;
		// infrared clock follows the serial 0 tick
		ta(8'h81);
		half(n);
		e0 = edges;
		repeat (10) half(n);
		`CK(n, 5)
		`CK(edges - e0, 5)
		PORT_LATCH_I <= 0;
		repeat (3) @(posedge CLK_I);
		`CK(CLOCK_OUTPUT_PIN_O, 1'b0)
		PORT_LATCH_I <= 1;
		ta(8'h00);
		$display("test clock pin done");
		// div13 per timer, and baud mode overriding it
		xfer(1, `TPC_ADDR_TIMER_CONFIG, 32'h1);
		repeat (2) @(posedge CLK_I);
		pulses(0, n);
		`CK(n, 10)
		T2_PIN_I <= 1;
		repeat (2) @(posedge CLK_I);
		`CK(T2_COUNT_O, 1'b1)
		T2_PIN_I <= 0;
		xfer(1, `TPC_ADDR_TIMER_CONFIG, 32'h2);
		repeat (12) @(posedge CLK_I);
		T1_PIN_I <= 1;
		repeat (2) @(posedge CLK_I);
		`CK(T1_COUNT_O, 1'b1)
		pulses(1, n);
		`CK(n, 10)
		TIMER2_RELOAD_SELECT_N_I <= 0;
		TIMER2_RX_CLOCK_SELECT_I <= 1;
		repeat (2) @(posedge CLK_I);
		pulses(1, n);
		`CK(n, 0)
		T2_PIN_I <= 1;
		repeat (2) @(posedge CLK_I);
		`CK(T2_COUNT_O, 1'b1)
		// baud decode and serial 1 double masking, all eight cases
		for (int i = 0; i < 8; i++) begin
			{TIMER2_RELOAD_SELECT_N_I, TIMER2_RX_CLOCK_SELECT_I,
				TIMER2_TX_CLOCK_SELECT_I} <= i[2:0];
			repeat (2) @(posedge CLK_I);
			`CK(TIMER2_BAUD_MODE_O, !i[2] && i[1:0] != 0)
			`CK(SERIAL1_RX_DOUBLE_O, !i[1])
			`CK(SERIAL1_TX_DOUBLE_O, !i[0])
		end
		$display("test timers done");
		conclude;
	end
endmodule
